// [rcs_params.svh]
// Purpose: Constants of the reset control sequencer
// Assumes: Included by bare name
// Notes: Counts are in system clock cycles
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH
`define RCS_STRETCH_CYC 512
`define RCS_CNT_W 10
`define RCS_RISE_CYC 14
`define RCS_RISE_W 4
`define RCS_MODE_W 2
`define RCS_MODE_RST 2'h3
`endif

// [rcs_pkg.sv]
// Purpose: Types of the reset control sequencer
// Assumes: Nothing
// Notes: States of the sequencer
package rcs_pkg;
  typedef enum logic [2:0] {
    RCS_IDLE,
    RCS_WAIT_BUS,
    RCS_STRETCH,
    RCS_HOLD,
    RCS_RISE
  } rcs_state_t;
endpackage

// [rcs_stretch_if.sv]
// Purpose: Link between sequencer and its stretch counter
// Assumes: One clock domain
// Notes: start is a one-cycle pulse
`timescale 1ns/1ns
interface rcs_stretch_if;
  logic start;
  logic run;
  logic done;
  modport ctl (output start, output run, input done);
  modport cnt (input start, input run, output done);
endinterface

// [rcs_sync.sv]
// Purpose: Two flip-flop synchroniser per bit
// Assumes: Inputs come from pins
// Notes: First stage feeds only the second
`timescale 1ns/1ns
module rcs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meta_q <= RST;
      o_q <= RST;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

// [rcs_stretch.sv]
// Purpose: Counts the reset stretch
// Assumes: Restarted by a start pulse
// Notes: Advances only while run is high
`timescale 1ns/1ns
`include "rcs_params.svh"
module rcs_stretch #(
  parameter int CYC = `RCS_STRETCH_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  rcs_stretch_if.cnt s
);
  localparam logic [`RCS_CNT_W-1:0] LAST = `RCS_CNT_W'(CYC);
  logic [`RCS_CNT_W-1:0] cnt_q;
  logic [`RCS_CNT_W-1:0] cnt_d;
  wire at_end = (cnt_q == LAST);
  assign cnt_d = s.start ? '0 : (s.run && !at_end) ? cnt_q + 1'b1 : cnt_q;
  assign s.done = at_end && !s.start;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_q <= LAST;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// [rcs_reset_seq.sv]
// Purpose: Reset control sequencer of the device
// Assumes: Bus, core and clock module signals share i_sys_clk
// Notes: Reset pins are open drain, modelled as in, out and enable
//
// How it works
// - Five reset lines are driven separately from the sequencer state.
// - System line drives hard and soft pins; soft line drives soft pin only.
// - Clock, system and general lines go to their own circuit groups.
// - Synchronous sources wait for the bus cycle end, locked or not.
// - Bus monitor is enabled while a synchronous reset waits.
// - Asynchronous sources reset at once, mid cycle.
// - Entering reset aborts the running cycle and, except for the reset instruction, readies exception state.
// - Hard pin, power-up, double fault, clock loss assert all four; watchdog not clock.
// - Soft pin asserts general line and soft line only.
// - Reset instruction asserts general and soft lines, no exception.
// - Soft pin pulled low: drive soft reset for 512 cycles.
// - Hard pin pulled low: drive hard and soft reset for 512 cycles.
// - Release only when pins are free and the stretch has run out.
// - Other sources: at least 512 cycles and until the source negates.
// - Wait 14 cycles for pin rise, test pins, then fetch vectors.
// - During reset the bus floats, fixed signals held inactive.
// - On release: controls inactive, data reads, address driven, first cycle.
// - Mode pins sampled during clock module reset; release 512 clocks after PLL lock.
// - Arbiter reset only on power-up.
// - In slave mode the reset instruction source does not exist.
// - Soft reset leaves boot select alone; low vectors must stay mapped.
`timescale 1ns/1ns
`include "rcs_params.svh"
module rcs_reset_seq #(
  parameter int STRETCH_CYC = `RCS_STRETCH_CYC,
  parameter int RISE_CYC = `RCS_RISE_CYC,
  parameter int MODE_W = `RCS_MODE_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_hard_reset_pin_n,
  output logic o_hard_reset_pin_n,
  output logic o_hard_reset_pin_oe,
  input wire logic i_soft_reset_pin_n,
  output logic o_soft_reset_pin_n,
  output logic o_soft_reset_pin_oe,
  input wire logic i_power_up,
  input wire logic i_watchdog,
  input wire logic i_double_fault,
  input wire logic i_clock_loss,
  input wire logic i_reset_instr,
  input wire logic i_slave_mode,
  input wire logic i_bus_cycle_active,
  input wire logic i_pll_locked,
  input wire logic [MODE_W-1:0] i_clock_mode_pins,
  output logic o_ext_system_reset_line,
  output logic o_ext_soft_reset_line,
  output logic o_clock_module_reset,
  output logic o_internal_system_reset,
  output logic o_general_internal_reset,
  output logic o_bus_monitor_en,
  output logic o_bus_abort,
  output logic o_core_regs_init,
  output logic o_bus_hiz,
  output logic o_data_read_dir,
  output logic o_addr_drive,
  output logic o_first_cycle_start,
  output logic o_arbiter_reset,
  output logic o_boot_select_restore,
  output logic o_pll_init,
  output logic [MODE_W-1:0] o_clock_mode
);
  import rcs_pkg::*;

  // ********************
  // Pin synchronisers
  // ********************
  logic hard_s;
  logic soft_s;
  logic lock_s;
  logic [MODE_W-1:0] mode_s;
  rcs_sync #(.W(3), .RST(3'h3)) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_pll_locked, i_soft_reset_pin_n, i_hard_reset_pin_n}),
    .o_q({lock_s, soft_s, hard_s})
  );
  rcs_sync #(.W(MODE_W), .RST(MODE_W'(`RCS_MODE_RST))) u_mode_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_clock_mode_pins),
    .o_q(mode_s)
  );

  // ********************
  // Stretch counter
  // ********************
  rcs_stretch_if s_if ();
  rcs_stretch #(.CYC(STRETCH_CYC)) u_stretch (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .s(s_if)
  );

  // ********************
  // Source decode
  // ********************
  rcs_state_t st_q;
  rcs_state_t st_d;
  logic sys_q;
  logic clk_q;
  logic pwr_q;
  logic exc_q;
  logic rd_dir_q;
  logic [MODE_W-1:0] mode_q;
  logic [`RCS_RISE_W-1:0] rise_q;
  localparam logic [`RCS_RISE_W-1:0] RISE_LAST = `RCS_RISE_W'(RISE_CYC - 1);

  wire idle_st = (st_q == RCS_IDLE);
  wire wait_st = (st_q == RCS_WAIT_BUS);
  wire str_st = (st_q == RCS_STRETCH);
  wire hold_st = (st_q == RCS_HOLD);
  wire rise_st = (st_q == RCS_RISE);
  wire watch = idle_st || wait_st;
  wire ext_hard = watch && !hard_s;
  wire ext_soft = idle_st && !soft_s;
  wire instr_hit = i_reset_instr && !i_slave_mode;
  wire clk_src = ext_hard || i_power_up || i_double_fault || i_clock_loss;
  wire sys_src = clk_src || i_watchdog;
  wire async_hit = sys_src || instr_hit;
  wire src_level = i_power_up || i_watchdog || i_double_fault || i_clock_loss;
  wire go_async = watch && async_hit;
  wire go_sync = wait_st && !async_hit && !i_bus_cycle_active;
  wire enter = go_async || go_sync;
  wire rise_end = rise_st && (rise_q == RISE_LAST);
  wire pins_low = !hard_s || !soft_s;
  wire release_ok = rise_end && !pins_low;
  wire drive = str_st || (hold_st && src_level);
  wire gen = str_st || hold_st || rise_st;

  // ********************
  // Sequencer
  // ********************
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      RCS_IDLE: begin
        if (async_hit) begin
          st_d = RCS_STRETCH;
        end else if (ext_soft) begin
          st_d = RCS_WAIT_BUS;
        end
      end
      RCS_WAIT_BUS: begin
        if (enter) begin
          st_d = RCS_STRETCH;
        end
      end
      RCS_STRETCH: begin
        if (s_if.done) begin
          st_d = RCS_HOLD;
        end
      end
      RCS_HOLD: begin
        if (!src_level && s_if.done) begin
          st_d = RCS_RISE;
        end
      end
      RCS_RISE: begin
        if (rise_end) begin
          st_d = pins_low ? RCS_HOLD : RCS_IDLE;
        end
      end
    endcase
  end

  assign s_if.start = enter;
  assign s_if.run = !clk_q || lock_s;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_q <= RCS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !rise_st) begin
      rise_q <= '0;
    end else if (!rise_end) begin
      rise_q <= rise_q + 1'b1;
    end
  end

  // Reset class, sticky while reset lasts
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sys_q <= 1'b0;
      clk_q <= 1'b0;
      pwr_q <= 1'b0;
      exc_q <= 1'b0;
    end else if (enter) begin
      sys_q <= sys_src;
      clk_q <= clk_src;
      pwr_q <= i_power_up;
      exc_q <= sys_src || go_sync;
    end else if (rise_end && pins_low) begin
      sys_q <= sys_q || !hard_s;
      clk_q <= clk_q || !hard_s;
      exc_q <= 1'b1;
    end else if (gen) begin
      sys_q <= sys_q || sys_src;
      clk_q <= clk_q || clk_src;
      pwr_q <= pwr_q || i_power_up;
      exc_q <= exc_q || sys_src;
    end
  end

  // In a clock module reset, mode pins follow the pins until the stretch ends
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode_q <= MODE_W'(`RCS_MODE_RST);
    end else if ((enter && clk_src) || (str_st && clk_q && !s_if.done)) begin
      mode_q <= mode_s;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || gen) begin
      rd_dir_q <= 1'b1;
    end else if (i_bus_cycle_active) begin
      rd_dir_q <= 1'b0;
    end
  end

  // ********************
  // Outputs
  // ********************
  assign o_general_internal_reset = gen;
  assign o_internal_system_reset = gen && sys_q;
  assign o_clock_module_reset = gen && clk_q;
  assign o_ext_system_reset_line = drive && sys_q;
  assign o_ext_soft_reset_line = drive && !sys_q;
  assign o_hard_reset_pin_oe = o_ext_system_reset_line;
  assign o_soft_reset_pin_oe = drive;
  assign o_hard_reset_pin_n = 1'b0;
  assign o_soft_reset_pin_n = 1'b0;
  assign o_bus_monitor_en = wait_st;
  assign o_bus_abort = go_async && i_bus_cycle_active;
  assign o_core_regs_init = gen && exc_q;
  assign o_bus_hiz = gen;
  assign o_data_read_dir = rd_dir_q;
  assign o_addr_drive = !gen;
  assign o_first_cycle_start = release_ok && exc_q;
  assign o_arbiter_reset = gen && pwr_q;
  assign o_boot_select_restore = gen && sys_q;
  assign o_pll_init = enter && clk_src;
  assign o_clock_mode = mode_q;

  // ********************
  // Checks
  // ********************
  logic [`RCS_CNT_W:0] drv_q;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !drive) begin
      drv_q <= '0;
    end else if (drv_q != '1) begin
      drv_q <= drv_q + 1'b1;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  pins_paired_a: assert property (
    o_hard_reset_pin_oe |-> o_soft_reset_pin_oe && o_ext_system_reset_line)
    else $error("hard pin driven without soft pin");
  clock_subset_a: assert property (
    o_clock_module_reset |-> o_internal_system_reset && o_general_internal_reset)
    else $error("clock reset outside system reset");
  sync_held_a: assert property (
    wait_st && i_bus_cycle_active && !async_hit |=> !o_general_internal_reset)
    else $error("synchronous reset taken mid cycle");
  monitor_on_a: assert property (
    idle_st && !soft_s && !async_hit |=> o_bus_monitor_en[*1])
    else $error("bus monitor not enabled");
  async_now_a: assert property (
    idle_st && i_power_up |=> o_general_internal_reset && o_ext_system_reset_line
      && o_clock_module_reset)
    else $error("asynchronous reset delayed");
  watchdog_set_a: assert property (
    idle_st && i_watchdog && !clk_src |=> o_internal_system_reset && !o_clock_module_reset)
    else $error("watchdog reset lines wrong");
  instr_set_a: assert property (
    idle_st && instr_hit && !sys_src |=> o_ext_soft_reset_line && !o_ext_system_reset_line
      && !o_core_regs_init)
    else $error("reset instruction lines wrong");
  stretch_min_a: assert property (
    $fell(o_soft_reset_pin_oe) |-> $past(drv_q) >= (`RCS_CNT_W + 1)'(STRETCH_CYC))
    else $error("reset pin released early");
  rise_wait_a: assert property (
    $rose(rise_st) |-> ##13 rise_st)
    else $error("pin rise window too short");
  slave_instr_a: assert property (
    idle_st && i_slave_mode && i_reset_instr && !sys_src && soft_s |=> !gen)
    else $error("reset instruction acted in slave mode");
  arbiter_pwr_a: assert property (
    o_arbiter_reset |-> o_internal_system_reset && pwr_q)
    else $error("arbiter reset without power-up");
  release_free_a: assert property (
    o_first_cycle_start |-> hard_s && soft_s && !o_soft_reset_pin_oe)
    else $error("release while a pin is low");
  abort_pulse_a: assert property (
    o_bus_abort |=> o_general_internal_reset && !o_bus_abort)
    else $error("bus abort without immediate reset");
  pll_start_a: assert property (
    o_pll_init |=> o_clock_module_reset && o_general_internal_reset)
    else $error("pll started outside a clock reset");
  mode_frozen_a: assert property (
    !o_general_internal_reset && !o_pll_init |=> $stable(o_clock_mode))
    else $error("clock mode changed outside reset");
  read_dir_a: assert property (
    $fell(o_general_internal_reset) |-> o_data_read_dir && o_addr_drive && !o_bus_hiz)
    else $error("bus not set for first cycle");
  release_late_a: assert property (
    $fell(o_general_internal_reset) |-> $past(hard_s) && $past(soft_s))
    else $error("reset released while a pin is low");
  first_once_a: assert property (
    o_first_cycle_start |=> !o_general_internal_reset && !o_first_cycle_start)
    else $error("vector fetch start not followed by release");
  soft_pin_a: assert property (
    o_ext_soft_reset_line |-> o_soft_reset_pin_oe && !o_hard_reset_pin_oe)
    else $error("soft line drove the hard pin");
  boot_keep_a: assert property (
    o_ext_soft_reset_line |-> !o_boot_select_restore)
    else $error("soft reset restored boot select");
  monitor_wait_a: assert property (
    o_bus_monitor_en |-> !o_general_internal_reset && !o_soft_reset_pin_oe)
    else $error("bus monitor on during reset");

  ext_hard_c: cover property (idle_st && !hard_s ##1 str_st);
  ext_soft_c: cover property (wait_st && i_bus_cycle_active ##1 wait_st ##1 str_st);
  instr_c: cover property ($fell(o_soft_reset_pin_oe) && !sys_q);
  boot_c: cover property (o_first_cycle_start);
  lock_wait_c: cover property (str_st && clk_q && !lock_s ##1 str_st);
endmodule

// [rcs_ext_dev.sv]
// Purpose: Far-side system device sharing the hard and soft reset pins
// Assumes: Pins are open drain with pull-ups, resolved by the bench
// Notes: A start pulse pulls the chosen pin low for the hold count, at least 32 cycles
`timescale 1ns/1ns
module rcs_ext_dev (
  input wire logic i_sys_clk,
  input wire logic i_hard_go,
  input wire logic i_soft_go,
  input wire logic [11:0] i_hold,
  output logic o_hard_oe,
  output logic o_soft_oe
);
  logic [11:0] cnt_q;
  logic [11:0] hold_min;
  // ************
  // Pin pull
  // ************
  assign hold_min = (i_hold < 12'h020) ? 12'h020 : i_hold;
  initial begin
    cnt_q = 12'h000;
    o_hard_oe = 1'b0;
    o_soft_oe = 1'b0;
  end
  always @(posedge i_sys_clk) begin
    if (i_hard_go || i_soft_go) begin
      cnt_q <= hold_min - 12'h001;
      o_hard_oe <= i_hard_go;
      o_soft_oe <= i_soft_go;
    end else if (cnt_q != 12'h000) begin
      cnt_q <= cnt_q - 12'h001;
    end else begin
      o_hard_oe <= 1'b0;
      o_soft_oe <= 1'b0;
    end
  end
endmodule

// [reset_control_sequencer_tb_top.sv]
// Purpose: Self-checking bench of the reset control sequencer
// Assumes: Stretch shortened to 48 cycles
// Notes: Inputs change on the falling edge
`timescale 1ns/1ns
module reset_control_sequencer_tb_top;
  localparam int STRETCH = 48;
  localparam int RISE = 14;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic hard_go = 1'b0, soft_go = 1'b0, instr = 1'b0, slave = 1'b0, bus_act = 1'b0;
  logic [11:0] hold = 12'h020;
  logic [3:0] src_v = 4'h0;
  logic [1:0] mode_pins = 2'h3;
  logic dev_hard_oe, dev_soft_oe, hard_n, soft_n, hard_oe, soft_oe, sys_line, soft_line;
  logic clk_rst, isys_rst, gen_rst, mon_en, abort, regs_init, hiz, rd_dir, addr_drv;
  logic first_cyc, arb_rst, boot_rst, abort_seen, first_seen;
  logic [1:0] mode_o;
  logic hard_pin_n, soft_pin_n;
  logic lock = 1'b1, pll_init, pll_seen;
  int failures = 0;
  int num_checks = 0;
  // ************
  // Wiring
  // ************
  always #5 i_sys_clk = ~i_sys_clk;
  assign hard_pin_n = ~(hard_oe | dev_hard_oe);
  assign soft_pin_n = ~(soft_oe | dev_soft_oe);
  // Abort and PLL start pulses stand from the falling edge to the next rising edge; first_cyc stands a whole cycle
  always @(posedge i_sys_clk) begin
    if (abort === 1'b1) abort_seen = 1'b1;
    if (first_cyc === 1'b1) first_seen = 1'b1;
    if (pll_init === 1'b1) pll_seen = 1'b1;
  end
  rcs_ext_dev dev (.i_sys_clk(i_sys_clk), .i_hard_go(hard_go), .i_soft_go(soft_go),
    .i_hold(hold), .o_hard_oe(dev_hard_oe), .o_soft_oe(dev_soft_oe));
  rcs_reset_seq #(.STRETCH_CYC(STRETCH), .RISE_CYC(RISE), .MODE_W(2)) dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_hard_reset_pin_n(hard_pin_n),
    .o_hard_reset_pin_n(hard_n), .o_hard_reset_pin_oe(hard_oe),
    .i_soft_reset_pin_n(soft_pin_n), .o_soft_reset_pin_n(soft_n),
    .o_soft_reset_pin_oe(soft_oe), .i_power_up(src_v[0]), .i_double_fault(src_v[1]),
    .i_clock_loss(src_v[2]), .i_watchdog(src_v[3]), .i_reset_instr(instr),
    .i_slave_mode(slave), .i_bus_cycle_active(bus_act), .i_pll_locked(lock),
    .i_clock_mode_pins(mode_pins), .o_ext_system_reset_line(sys_line),
    .o_ext_soft_reset_line(soft_line), .o_clock_module_reset(clk_rst),
    .o_internal_system_reset(isys_rst), .o_general_internal_reset(gen_rst),
    .o_bus_monitor_en(mon_en), .o_bus_abort(abort), .o_core_regs_init(regs_init),
    .o_bus_hiz(hiz), .o_data_read_dir(rd_dir), .o_addr_drive(addr_drv),
    .o_first_cycle_start(first_cyc), .o_arbiter_reset(arb_rst),
    .o_boot_select_restore(boot_rst), .o_pll_init(pll_init), .o_clock_mode(mode_o));
  // ************
  // Helpers
  // ************
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_low(input int lim, output int n);
    n = 0;
    while (gen_rst !== 1'b0 && n < lim) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n >= lim) begin
      chk(1'b0, "reset never released");
      wrap_up();
    end
  endtask
  // ************
  // Scenarios
  // ************
  task automatic run_async(input int idx, input logic exp_clk, input logic exp_arb);
    int n;
    repeat (3) @(negedge i_sys_clk);
    abort_seen = 1'b0;
    first_seen = 1'b0;
    pll_seen = 1'b0;
    lock = (idx != 0);
    bus_act = 1'b1;
    mode_pins = 2'(idx + 1);
    src_v = 4'h1 << idx;
    @(negedge i_sys_clk);
    bus_act = 1'b0;
    chk(gen_rst === 1'b1 && isys_rst === 1'b1 && sys_line === 1'b1, "async lines");
    chk(clk_rst === exp_clk && arb_rst === exp_arb, "clock or arbiter line");
    chk(hard_oe === 1'b1 && soft_oe === 1'b1 && soft_line === 1'b0, "pins");
    chk(hiz === 1'b1 && addr_drv === 1'b0 && regs_init === 1'b1, "bus float");
    chk(abort_seen === 1'b1, "cycle not aborted");
    chk(hard_n === 1'b0 && soft_n === 1'b0 && pll_seen === exp_clk, "pin or pll");
    repeat (STRETCH + 12) @(negedge i_sys_clk);
    chk(gen_rst === 1'b1 && hard_oe === 1'b1, "released while source high");
    src_v = 4'h0;
    if (idx == 0) begin
      repeat (RISE + 8) @(negedge i_sys_clk);
      chk(gen_rst === 1'b1 && soft_oe === 1'b1, "released before pll lock");
      lock = 1'b1;
    end
    wait_low(400, n);
    chk(n >= (idx == 0 ? STRETCH : RISE) && first_seen === 1'b1, "rise or fetch");
    chk(hiz === 1'b0 && addr_drv === 1'b1 && rd_dir === 1'b1, "bus after release");
    if (exp_clk)
      chk(mode_o === 2'(idx + 1), "clock mode sample");
  endtask
  task automatic run_instr();
    int n;
    repeat (3) @(negedge i_sys_clk);
    first_seen = 1'b0;
    instr = 1'b1;
    @(negedge i_sys_clk);
    instr = 1'b0;
    chk(gen_rst === 1'b1 && soft_line === 1'b1 && soft_oe === 1'b1, "instr lines");
    chk(hard_oe === 1'b0 && isys_rst === 1'b0 && regs_init === 1'b0, "instr extra");
    wait_low(2000, n);
    chk(n >= STRETCH - 1 && first_seen === 1'b0, "instr length or fetch");
  endtask
  task automatic run_slave();
    logic bad;
    bad = 1'b0;
    slave = 1'b1;
    instr = 1'b1;
    @(negedge i_sys_clk);
    instr = 1'b0;
    repeat (5) begin
      @(negedge i_sys_clk);
      if (gen_rst !== 1'b0) bad = 1'b1;
    end
    chk(!bad, "instr taken in slave mode");
    slave = 1'b0;
  endtask
  task automatic run_soft();
    int n;
    repeat (3) @(negedge i_sys_clk);
    bus_act = 1'b1;
    hold = 12'h020;
    soft_go = 1'b1;
    @(negedge i_sys_clk);
    soft_go = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    chk(mon_en === 1'b1 && gen_rst === 1'b0, "not held for bus cycle");
    bus_act = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    chk(gen_rst === 1'b1 && soft_line === 1'b1 && soft_oe === 1'b1, "soft lines");
    chk(isys_rst === 1'b0 && clk_rst === 1'b0 && hard_oe === 1'b0, "soft extra");
    chk(boot_rst === 1'b0, "boot select restored");
    wait_low(2000, n);
    chk(n >= STRETCH - 3, "soft stretch short");
  endtask
  task automatic run_hard();
    int n;
    repeat (3) @(negedge i_sys_clk);
    hold = 12'h064;
    hard_go = 1'b1;
    @(negedge i_sys_clk);
    hard_go = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    chk(gen_rst === 1'b1 && hard_oe === 1'b1 && soft_oe === 1'b1, "hard pins");
    chk(sys_line === 1'b1 && clk_rst === 1'b1 && isys_rst === 1'b1, "hard lines");
    wait_low(2000, n);
    chk(n >= 90, "released while pin held");
  endtask
  initial begin
    repeat (4) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    @(negedge i_sys_clk);
    chk(gen_rst === 1'b0 && rd_dir === 1'b1 && mode_o === 2'h3, "reset values");
    run_async(0, 1'b1, 1'b1);
    run_async(1, 1'b1, 1'b0);
    run_async(2, 1'b1, 1'b0);
    run_async(3, 1'b0, 1'b0);
    run_instr();
    run_slave();
    run_soft();
    run_hard();
    wrap_up();
  end
endmodule
